// [hdl/cfm_defs.svh]
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH

// register byte offsets
`define CFM_OFS_SEL_LO   7'h00
`define CFM_OFS_SEL_HI   7'h04
`define CFM_OFS_MSID0    7'h08
`define CFM_OFS_MSID1    7'h0C
`define CFM_OFS_MSID2    7'h10
`define CFM_OFS_MEID0    7'h14
`define CFM_OFS_MEID1    7'h18
`define CFM_OFS_MEID2    7'h1C
`define CFM_OFS_FULL_LO  7'h20
`define CFM_OFS_FULL_HI  7'h24
`define CFM_OFS_OVF_LO   7'h28
`define CFM_OFS_OVF_HI   7'h2C
`define CFM_OFS_CTL0     7'h30
`define CFM_OFS_CTL3     7'h3C
`define CFM_OFS_INT_STAT 7'h40
`define CFM_OFS_INT_MASK 7'h44
// field positions
`define CFM_SID_LSB      5
`define CFM_ID_TYPE_MATCH_MODE_BIT     3
`define CFM_CTL_DIR      7
`define CFM_CTL_ABT      6
`define CFM_CTL_LARB     5
`define CFM_CTL_ERR      4
`define CFM_CTL_REQ      3
`define CFM_CTL_AUTO_REMOTE_REPLY    2
`define CFM_INT_RXSTORE  0
`define CFM_INT_RX_BUFFER_OVERFLOW    1
`define CFM_INT_TXDONE   2
`define CFM_INT_TX_BUS_ERROR    3
`define CFM_INT_LARB     4
// reset values and sizes
`define CFM_RST16        16'h0000
`define CFM_FIFO_PTR     4'hF
`define CFM_NUM_TXB      8
`endif

// [hdl/cfm_filter_status.sv]
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cfm_defs.svh"
module cfm_filter_status (
	// clock, reset, enable
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// avalon-mm register slave
	input  wire logic [6:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	// protocol engine side
	input  wire cfm_pkg::cfm_rx_req_t rxReq,
	input  wire cfm_pkg::cfm_tx_evt_t txEvt,
	// message memory writes and transmit selection
	output cfm_pkg::cfm_dma_wr_t      dmaWr,
	output cfm_pkg::cfm_tx_sel_t      txSel,
	output logic [7:0]                abortReq,
	// interrupt
	output logic                      irq
);
	import cfm_pkg::*;

	cfm_state_t   st_r;
	cfm_state_t   st_nxt;

	// bus decode and read path
	logic         busReq;
	logic         busTake;
	logic         busWr;
	logic         ctlHit;
	logic [15:0]  laneMask;
	logic [15:0]  wd;
	logic [31:0]  rdVal;
	// filter evaluation and receive routing
	logic [31:0]  selAll;
	cfm_msk_src_t mskSrc;
	cfm_msk_sid_t mSidSel;
	logic [15:0]  mEidSel;
	logic         sidHit;
	logic         eidHit;
	logic         typeOk;
	logic         accept;
	logic [3:0]   rxIdx;
	logic         rxToFifo;
	logic         rxLost;
	logic         rxStore;
	// pair control write, both halves of one pair word
	logic [2:0]   pairIdx;
	logic [15:0]  pairOld;
	logic [15:0]  pairNew;
	logic [1:0]   pairAbort;
	// transmit pick
	logic         pickV;
	logic [2:0]   pickIdx;
	logic [1:0]   pickPri;

	// outputs come straight from the state flops
	assign avs_readdata    = st_r.rdData;
	assign avs_waitrequest = st_r.waitReq;
	assign dmaWr           = st_r.dmaWr;
	assign txSel           = st_r.txSel;
	assign abortReq        = st_r.abortReq;
	assign irq             = st_r.irq;

	// bus request decode; only the two low byte lanes hold register bits
	assign busReq   = avs_read | avs_write;
	assign busTake  = busReq & ~st_r.waitReq;
	assign busWr    = busTake & avs_write;
	assign laneMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wd       = avs_writedata[15:0];
	assign pairIdx  = 3'((avs_address - `CFM_OFS_CTL0) >> 1);
	// pair control words sit in a block of four aligned words
	assign ctlHit   = (avs_address >= `CFM_OFS_CTL0) &&
	                  (avs_address <= `CFM_OFS_CTL3) &&
	                  (avs_address[1:0] == 2'b00);

	// read mux, prepared one cycle before the data is taken
	always_comb begin
		rdVal = 32'h0000_0000;
		unique case (avs_address)
			`CFM_OFS_SEL_LO:   rdVal[15:0] = st_r.selLo;
			`CFM_OFS_SEL_HI:   rdVal[15:0] = st_r.selHi;
			`CFM_OFS_MSID0:    rdVal[15:0] = sidWord(st_r.mSid[0]);
			`CFM_OFS_MSID1:    rdVal[15:0] = sidWord(st_r.mSid[1]);
			`CFM_OFS_MSID2:    rdVal[15:0] = sidWord(st_r.mSid[2]);
			`CFM_OFS_MEID0:    rdVal[15:0] = st_r.mEid[0];
			`CFM_OFS_MEID1:    rdVal[15:0] = st_r.mEid[1];
			`CFM_OFS_MEID2:    rdVal[15:0] = st_r.mEid[2];
			`CFM_OFS_FULL_LO:  rdVal[15:0] = st_r.rxFull[15:0];
			`CFM_OFS_FULL_HI:  rdVal[15:0] = st_r.rxFull[31:16];
			`CFM_OFS_OVF_LO:   rdVal[15:0] = st_r.rx_buffer_overflow[15:0];
			`CFM_OFS_OVF_HI:   rdVal[15:0] = st_r.rx_buffer_overflow[31:16];
			`CFM_OFS_INT_STAT: rdVal[4:0]  = st_r.intStat;
			`CFM_OFS_INT_MASK: rdVal[4:0]  = st_r.intMask;
			default: begin
				// unmapped words read as zero; no error is raised
				if (ctlHit) begin
					rdVal[15:0] = pairOld;
				end
			end
		endcase
	end

	// packs a mask SID entry; bits 4 and 2 stay zero
	function automatic logic [15:0] sidWord(input logic [13:0] f);
		cfm_msk_sid_t m;
		m = f;
		sidWord = {m.sid, 1'b0, m.id_type_match_mode, 1'b0, m.eidHi};
	endfunction

	// unpacks a written SID word into the stored fields
	function automatic logic [13:0] sidField(input logic [15:0] w);
		cfm_msk_sid_t m;
		m.sid   = w[15:`CFM_SID_LSB];
		m.id_type_match_mode  = w[`CFM_ID_TYPE_MATCH_MODE_BIT];
		m.eidHi = w[1:0];
		sidField = m;
	endfunction

	// mask source of the filter under test
	assign selAll = {st_r.selHi, st_r.selLo};
	assign mskSrc = cfm_msk_src_t'(selAll[{rxReq.fltNum, 1'b0} +: 2]);

	// pick the mask set; no mask means every bit is compared exactly
	always_comb begin
		mSidSel = '1;
		mEidSel = 16'hFFFF;
		// two-bit selector: every code is decoded, none is illegal
		unique case (mskSrc)
			CFM_MSK_SET0: begin
				mSidSel = st_r.mSid[0];
				mEidSel = st_r.mEid[0];
			end
			CFM_MSK_SET1: begin
				mSidSel = st_r.mSid[1];
				mEidSel = st_r.mEid[1];
			end
			CFM_MSK_SET2: begin
				mSidSel = st_r.mSid[2];
				mEidSel = st_r.mEid[2];
			end
			CFM_MSK_NONE: begin
				mSidSel = '1;
				mEidSel = 16'hFFFF;
			end
		endcase
	end

	// masked comparison: a zero mask bit never blocks a match
	assign sidHit = ((rxReq.msgSid ^ rxReq.fltSid) & mSidSel.sid)
	                == 11'h000;
	assign eidHit = ((rxReq.msgEid ^ rxReq.fltEid) &
	                 {mSidSel.eidHi, mEidSel}) == 18'h00000;
	// standard frames carry no extended bits, so the EID compare is skipped for them
	assign typeOk = ~mSidSel.id_type_match_mode |
	                (rxReq.msgIde == rxReq.fltExide);
	assign accept = rxReq.valid & sidHit & typeOk &
	                (~rxReq.msgIde | eidHit);
	assign rxIdx  = rxReq.fltBufPtr;
	// where an accepted frame goes: fifo, a free buffer, or nowhere
	assign rxToFifo = accept & (rxIdx == `CFM_FIFO_PTR);
	assign rxLost   = accept & ~rxToFifo & st_r.rxFull[rxIdx];
	assign rxStore  = accept & ~rxToFifo & ~st_r.rxFull[rxIdx];

	// next transmit candidate: highest priority, ties go to higher index
	always_comb begin
		pickV   = 1'b0;
		pickIdx = 3'd0;
		pickPri = 2'b00;
		// a buffer competes only while it transmits with a request pending
		for (int i = 0; i < `CFM_NUM_TXB; i++) begin
			if (st_r.ctl[i][`CFM_CTL_DIR] &&
			    st_r.ctl[i][`CFM_CTL_REQ] &&
			    (!pickV || st_r.ctl[i][1:0] >= pickPri)) begin
				pickV   = 1'b1;
				pickIdx = 3'(i);
				pickPri = st_r.ctl[i][1:0];
			end
		end
	end

	// pair control write, shared by both halves of a pair word;
	// a lane that is not enabled keeps its byte as it was
	always_comb begin
		pairOld   = {st_r.ctl[pairIdx + 3'd1], st_r.ctl[pairIdx]};
		pairNew   = pairOld;
		pairAbort = 2'b00;
		for (int h = 0; h < 2; h++) begin
			if (avs_byteenable[h]) begin
				pairNew[h*8 +: 8] = ctlWrite(pairOld[h*8 +: 8],
				                             wd[h*8 +: 8]);
				// clearing a pending request asks for abort
				pairAbort[h] = pairOld[h*8 + `CFM_CTL_REQ] &
				               ~wd[h*8 + `CFM_CTL_REQ];
			end
		end
	end

	// whole next state
	always_comb begin
		st_nxt          = st_r;
		st_nxt.dmaWr    = '0;
		st_nxt.abortReq = 8'h00;

		// one wait cycle per access, then the transfer at the low edge
		st_nxt.waitReq = ~(busReq & st_r.waitReq);
		if (busReq && st_r.waitReq) begin
			st_nxt.rdData = rdVal;
		end

		// software writes, applied before hardware sets so sets win
		if (busWr) begin
			unique case (avs_address)
				`CFM_OFS_SEL_LO:
					st_nxt.selLo = (wd & laneMask) |
					               (st_r.selLo & ~laneMask);
				`CFM_OFS_SEL_HI:
					st_nxt.selHi = (wd & laneMask) |
					               (st_r.selHi & ~laneMask);
				`CFM_OFS_MSID0:
					st_nxt.mSid[0] = sidField((wd & laneMask) |
					    (sidWord(st_r.mSid[0]) & ~laneMask));
				`CFM_OFS_MSID1:
					st_nxt.mSid[1] = sidField((wd & laneMask) |
					    (sidWord(st_r.mSid[1]) & ~laneMask));
				`CFM_OFS_MSID2:
					st_nxt.mSid[2] = sidField((wd & laneMask) |
					    (sidWord(st_r.mSid[2]) & ~laneMask));
				`CFM_OFS_MEID0:
					st_nxt.mEid[0] = (wd & laneMask) |
					                 (st_r.mEid[0] & ~laneMask);
				`CFM_OFS_MEID1:
					st_nxt.mEid[1] = (wd & laneMask) |
					                 (st_r.mEid[1] & ~laneMask);
				`CFM_OFS_MEID2:
					st_nxt.mEid[2] = (wd & laneMask) |
					                 (st_r.mEid[2] & ~laneMask);
				// zero clears, one leaves the flag alone
				`CFM_OFS_FULL_LO:
					st_nxt.rxFull[15:0] = st_r.rxFull[15:0] &
					                      (wd | ~laneMask);
				`CFM_OFS_FULL_HI:
					st_nxt.rxFull[31:16] = st_r.rxFull[31:16] &
					                       (wd | ~laneMask);
				`CFM_OFS_OVF_LO:
					st_nxt.rx_buffer_overflow[15:0] = st_r.rx_buffer_overflow[15:0] &
					                     (wd | ~laneMask);
				`CFM_OFS_OVF_HI:
					st_nxt.rx_buffer_overflow[31:16] = st_r.rx_buffer_overflow[31:16] &
					                      (wd | ~laneMask);
				// write one to clear an interrupt flag
				`CFM_OFS_INT_STAT:
					st_nxt.intStat = st_r.intStat &
					    ~(wd[4:0] & laneMask[4:0]);
				// mask bits fit in lane 0, so only that lane counts
				`CFM_OFS_INT_MASK:
					if (avs_byteenable[0]) begin
						st_nxt.intMask = wd[4:0];
					end
				default: begin
					// both halves come from the pair helper above
					if (ctlHit) begin
						st_nxt.ctl[pairIdx]             = pairNew[7:0];
						st_nxt.ctl[pairIdx + 3'd1]      = pairNew[15:8];
						st_nxt.abortReq[pairIdx]        = pairAbort[0];
						st_nxt.abortReq[pairIdx + 3'd1] = pairAbort[1];
					end
				end
			endcase
		end

		// accepted frames: route by buffer pointer, note the filter number
		if (rxToFifo) begin
			st_nxt.dmaWr.valid   = 1'b1;
			st_nxt.dmaWr.toFifo  = 1'b1;
			st_nxt.dmaWr.bufIdx  = rxIdx;
			st_nxt.dmaWr.hitCode = {1'b0, rxReq.fltNum};
			st_nxt.intStat[`CFM_INT_RXSTORE] = 1'b1;
		end else if (rxLost) begin
			// buffer still unread: keep its contents, flag the loss
			st_nxt.rx_buffer_overflow[rxIdx] = 1'b1;
			st_nxt.intStat[`CFM_INT_RX_BUFFER_OVERFLOW] = 1'b1;
		end else if (rxStore) begin
			// free buffer: mark it full and hand the frame to memory
			st_nxt.rxFull[rxIdx] = 1'b1;
			st_nxt.dmaWr.valid   = 1'b1;
			st_nxt.dmaWr.bufIdx  = rxIdx;
			st_nxt.dmaWr.hitCode = {1'b0, rxReq.fltNum};
			st_nxt.intStat[`CFM_INT_RXSTORE] = 1'b1;
		end

		// transmit engine results for one buffer
		if (txEvt.doneV) begin
			st_nxt.ctl[txEvt.idx][`CFM_CTL_REQ] = 1'b0;
			st_nxt.intStat[`CFM_INT_TXDONE] = 1'b1;
		end
		// an abort ends the request; lost arbitration and error keep it
		if (txEvt.abtV) begin
			st_nxt.ctl[txEvt.idx][`CFM_CTL_ABT] = 1'b1;
			st_nxt.ctl[txEvt.idx][`CFM_CTL_REQ] = 1'b0;
		end
		if (txEvt.larbV) begin
			st_nxt.ctl[txEvt.idx][`CFM_CTL_LARB] = 1'b1;
			st_nxt.intStat[`CFM_INT_LARB] = 1'b1;
		end
		if (txEvt.errV) begin
			st_nxt.ctl[txEvt.idx][`CFM_CTL_ERR] = 1'b1;
			st_nxt.intStat[`CFM_INT_TX_BUS_ERROR] = 1'b1;
		end

		// remote request answered by a transmit buffer set for it
		if (txEvt.rtrV &&
		    st_r.ctl[txEvt.rtrIdx][`CFM_CTL_AUTO_REMOTE_REPLY] &&
		    st_r.ctl[txEvt.rtrIdx][`CFM_CTL_DIR]) begin
			st_nxt.ctl[txEvt.rtrIdx][`CFM_CTL_REQ] = 1'b1;
		end

		// selection follows the current state, interrupt the updated state
		st_nxt.txSel.valid = pickV;
		st_nxt.txSel.idx   = pickIdx;
		st_nxt.txSel.pri   = pickPri;
		// irq follows the next state so it rises together with its flag
		st_nxt.irq = |(st_nxt.intStat & st_nxt.intMask);
	end

	// software view of one buffer's control byte; status bits are kept,
	// and a fresh request wipes the previous attempt's outcome
	function automatic logic [7:0] ctlWrite(input logic [7:0] old,
	                                        input logic [7:0] w);
		logic [7:0] n;
		n = old;
		n[`CFM_CTL_DIR]   = w[`CFM_CTL_DIR];
		n[`CFM_CTL_REQ]   = w[`CFM_CTL_REQ];
		n[`CFM_CTL_AUTO_REMOTE_REPLY] = w[`CFM_CTL_AUTO_REMOTE_REPLY];
		n[1:0]            = w[1:0];
		if (!old[`CFM_CTL_REQ] && w[`CFM_CTL_REQ]) begin
			n[`CFM_CTL_ABT]  = 1'b0;
			n[`CFM_CTL_LARB] = 1'b0;
			n[`CFM_CTL_ERR]  = 1'b0;
		end
		ctlWrite = n;
	endfunction

	// single state register; clock enable freezes everything
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r         <= '0;
			st_r.selLo   <= `CFM_RST16;
			st_r.selHi   <= `CFM_RST16;
			st_r.rxFull  <= {`CFM_RST16, `CFM_RST16};
			st_r.rx_buffer_overflow   <= {`CFM_RST16, `CFM_RST16};
			// mask sets come up cleared: every bit don't-care until written
			st_r.mSid    <= '0;
			st_r.mEid    <= '0;
			// buffers idle, no status, no request pending
			st_r.ctl     <= '0;
			st_r.intStat <= 5'h00;
			st_r.intMask <= 5'h00;
			st_r.abortReq <= 8'h00;
			// outputs idle, except waitrequest, which holds off the bus
			st_r.dmaWr   <= '0;
			st_r.txSel   <= '0;
			st_r.rdData  <= 32'h0000_0000;
			st_r.irq     <= 1'b0;
			st_r.waitReq <= 1'b1;
		end else if (ce) begin
			// rst wins over ce, so a frozen block can still be reset
			st_r <= st_nxt;
		end
	end
endmodule

// [hdl/cfm_pkg.sv]
package cfm_pkg;
	typedef enum logic [1:0] {
		CFM_MSK_SET0 = 2'b00,
		CFM_MSK_SET1 = 2'b01,
		CFM_MSK_SET2 = 2'b10,
		CFM_MSK_NONE = 2'b11
	} cfm_msk_src_t;
	typedef struct packed {
		logic        valid;
		logic [10:0] msgSid;
		logic [17:0] msgEid;
		logic        msgIde;
		logic [3:0]  fltNum;
		logic [10:0] fltSid;
		logic [17:0] fltEid;
		logic        fltExide;
		logic [3:0]  fltBufPtr;
	} cfm_rx_req_t;
	typedef struct packed {
		logic       valid;
		logic       toFifo;
		logic [3:0] bufIdx;
		logic [4:0] hitCode;
	} cfm_dma_wr_t;
	typedef struct packed {
		logic       doneV;
		logic       abtV;
		logic       larbV;
		logic       errV;
		logic [2:0] idx;
		logic       rtrV;
		logic [2:0] rtrIdx;
	} cfm_tx_evt_t;
	typedef struct packed {
		logic       valid;
		logic [2:0] idx;
		logic [1:0] pri;
	} cfm_tx_sel_t;
	typedef struct packed {
		logic [10:0] sid;
		logic        id_type_match_mode;
		logic [1:0]  eidHi;
	} cfm_msk_sid_t;
	typedef struct packed {
		logic [15:0]             selLo;
		logic [15:0]             selHi;
		logic [2:0][13:0]        mSid;
		logic [2:0][15:0]        mEid;
		logic [31:0]             rxFull;
		logic [31:0]             rx_buffer_overflow;
		logic [7:0][7:0]         ctl;
		logic [4:0]              intStat;
		logic [4:0]              intMask;
		logic                    waitReq;
		logic [31:0]             rdData;
		logic                    irq;
		cfm_dma_wr_t             dmaWr;
		logic [7:0]              abortReq;
		cfm_tx_sel_t             txSel;
	} cfm_state_t;
endpackage

// [sim/cfm_engine_model.sv]
`timescale 1ns/1ps
module cfm_engine_model (
	// clock
	input  wire logic                 clk,
	// frames and transmit events toward the block
	output cfm_pkg::cfm_rx_req_t      rxReq,
	output cfm_pkg::cfm_tx_evt_t      txEvt,
	// message memory writes
	input  wire cfm_pkg::cfm_dma_wr_t dmaWr
);
	import cfm_pkg::*;
	logic [4:0] hit [0:15];
	int         cnt = 0;
	initial begin
		rxReq = '0;
		txEvt = '0;
	end
	// one frame for one filter; fields are scrambled once released
	task automatic rx(input logic [3:0] flt, input logic [10:0] ms,
		input logic [10:0] fs, input logic ide, input logic [3:0] ptr);
		cfm_rx_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.msgSid = ms;
		r.msgIde = ide;
		r.fltNum = flt;
		r.fltSid = fs;
		r.fltBufPtr = ptr;
		@(posedge clk);
		rxReq <= r;
		@(posedge clk);
		r = ~r;
		r.valid = 1'b0;
		rxReq <= r;
	endtask
	// one-cycle event pulse, index lines scrambled afterwards
	task automatic evt(input cfm_tx_evt_t e);
		cfm_tx_evt_t r;
		@(posedge clk);
		txEvt <= e;
		r = ~e;
		r.doneV = 1'b0;
		r.abtV = 1'b0;
		r.larbV = 1'b0;
		r.errV = 1'b0;
		r.rtrV = 1'b0;
		@(posedge clk);
		txEvt <= r;
	endtask
	// message memory: the block writes buffers here, not in registers
	always @(posedge clk) begin
		if (dmaWr.valid) begin
			cnt <= cnt + 1;
			if (!dmaWr.toFifo) begin
				hit[dmaWr.bufIdx] <= dmaWr.hitCode;
			end
		end
	end
endmodule

// [sim/cfm_filter_status_asserts.sv]
`timescale 1ns/1ps
module cfm_filter_status_asserts (
	// clock, reset, enable
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 ce,
	// register bus
	input wire logic                 avs_read,
	input wire logic                 avs_write,
	input wire logic [31:0]          avs_readdata,
	input wire logic                 avs_waitrequest,
	// engine side
	input wire cfm_pkg::cfm_rx_req_t rxReq,
	input wire cfm_pkg::cfm_dma_wr_t dmaWr,
	input wire logic [7:0]           abortReq,
	input wire logic                 irq
);
	import cfm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// bus answers after exactly one wait cycle
	wait_one_a: assert property (ce && $rose(avs_read | avs_write)
		|=> !avs_waitrequest) else $error("no answer after one wait");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	wait_cause_a: assert property (!avs_waitrequest
		|-> $past(avs_read | avs_write)) else $error("answer without request");
	rd_upper_a: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("upper read lanes not zero");
	// stores trace back to the offered frame one cycle before
	dma_cause_a: assert property (dmaWr.valid |-> $past(rxReq.valid))
		else $error("store without frame");
	hit_code_a: assert property (dmaWr.valid
		|-> dmaWr.hitCode == {1'b0, $past(rxReq.fltNum)})
		else $error("wrong hit code");
	fifo_route_a: assert property (dmaWr.valid
		|-> dmaWr.toFifo == ($past(rxReq.fltBufPtr) == 4'hF))
		else $error("wrong fifo routing");
	buf_index_a: assert property (dmaWr.valid && !dmaWr.toFifo
		|-> dmaWr.bufIdx == $past(rxReq.fltBufPtr))
		else $error("wrong buffer index");
	abort_pulse_a: assert property (abortReq != 8'h00
		|=> abortReq == 8'h00) else $error("abort not a pulse");
	cover property (dmaWr.valid && dmaWr.toFifo);
	cover property ($rose(irq));
	cover property (abortReq != 8'h00);
endmodule

bind cfm_filter_status cfm_filter_status_asserts u_chk (.clk, .rst, .ce,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .rxReq,
	.dmaWr, .abortReq, .irq);

// [sim/cfm_filter_status_tb_top.sv]
`timescale 1ns/1ps
module cfm_filter_status_tb_top;
	import cfm_pkg::*;
	// clock and register bus
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [6:0]  avs_address = 7'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	// engine side
	cfm_rx_req_t rxReq;
	cfm_tx_evt_t txEvt;
	cfm_dma_wr_t dmaWr;
	cfm_tx_sel_t txSel;
	logic [7:0]  abortReq;
	logic        irq;
	logic        abortSeen = 1'b0;
	logic [15:0] q;
	int          failCount = 0;
	int          checked = 0;
	int          expN = 0;
	cfm_filter_status dut (.clk, .rst, .ce, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .rxReq, .txEvt, .dmaWr, .txSel, .abortReq, .irq);
	cfm_engine_model eng (.clk, .rxReq, .txEvt, .dmaWr);
	initial begin
		forever #2.5 clk = ~clk;
	end
	// abort pulses are short, so latch buffer 1's pulse for a later look
	always @(posedge clk) begin
		if (abortReq[1]) begin
			abortSeen <= 1'b1;
		end
	end
	task automatic stopTest;
		if (failCount == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			failCount++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// one bus cycle, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [6:0] a,
		input logic [15:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= be;
		// waitrequest is sampled at the rising edge, as the slave sees it
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			failCount++;
			stopTest();
		end else begin
			q = avs_readdata[15:0];
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		acc(1'b1, a, d, 4'h3);
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000, 4'h3);
		chk(q, e);
	endtask
	// upper pair byte only, where the lower byte is left open
	task automatic rdu(input logic [7:0] e);
		acc(1'b0, 7'h30, 16'h0000, 4'h3);
		chk({8'h00, q[15:8]}, {8'h00, e});
	endtask
	task automatic rxc(input logic [3:0] f, input logic [10:0] ms,
		input logic [10:0] fs, input logic ide, input logic [3:0] p,
		input int ok);
		eng.rx(f, ms, fs, ide, p);
		repeat (2) @(posedge clk);
		expN += ok;
		chk(16'(eng.cnt), 16'(expN));
	endtask
	task automatic irqIs(input logic e);
		repeat (2) @(posedge clk);
		chk({15'h0000, irq}, {15'h0000, e});
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failCount++;
		stopTest();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({14'h0000, avs_waitrequest, dmaWr.valid}, 16'h0002);
		for (int i = 0; i <= 18; i++) begin
			rd(7'(4 * i), 16'h0000);
		end
		wr(7'h48, 16'hFFFF);
		rd(7'h48, 16'h0000);
		wr(7'h00, 16'hC6A5);
		acc(1'b1, 7'h00, 16'h00FF, 4'h1);
		rd(7'h00, 16'hC6FF);
		wr(7'h04, 16'h5A3C);
		rd(7'h04, 16'h5A3C);
		wr(7'h08, 16'hFFFF);
		rd(7'h08, 16'hFFEB);
		wr(7'h14, 16'hFFFF);
		rd(7'h14, 16'hFFFF);
		// set 0 strict, set 1 open, set 2 ids only; filter 3 and 8 unmasked
		wr(7'h10, 16'hFFE3);
		wr(7'h00, 16'h00E4);
		wr(7'h04, 16'h0003);
		rxc(4'h0, 11'h005, 11'h005, 1'b0, 4'h0, 1);
		rxc(4'h0, 11'h005, 11'h006, 1'b0, 4'h1, 0);
		rxc(4'h0, 11'h005, 11'h005, 1'b1, 4'h2, 0);
		rxc(4'h1, 11'h007, 11'h001, 1'b1, 4'h3, 1);
		rxc(4'h2, 11'h009, 11'h009, 1'b1, 4'h4, 1);
		rxc(4'h2, 11'h009, 11'h008, 1'b0, 4'h5, 0);
		rxc(4'h3, 11'h003, 11'h003, 1'b1, 4'h6, 0);
		rxc(4'h3, 11'h003, 11'h003, 1'b0, 4'h7, 1);
		rxc(4'h8, 11'h002, 11'h003, 1'b0, 4'h8, 0);
		rxc(4'h8, 11'h002, 11'h002, 1'b0, 4'hE, 1);
		rxc(4'h0, 11'h004, 11'h004, 1'b0, 4'hF, 1);
		chk({11'h000, eng.hit[14]}, 16'h0008);
		chk({11'h000, eng.hit[3]}, 16'h0001);
		rd(7'h20, 16'h4099);
		rd(7'h24, 16'h0000);
		// a store into a full buffer is dropped and flagged
		rxc(4'h1, 11'h000, 11'h000, 1'b0, 4'h0, 0);
		rd(7'h28, 16'h0001);
		wr(7'h20, 16'hFFFE);
		// a frame offered while ce is low must leave no trace
		ce <= 1'b0;
		rxc(4'h3, 11'h003, 11'h003, 1'b0, 4'h9, 0);
		ce <= 1'b1;
		rd(7'h20, 16'h4098);
		wr(7'h28, 16'h0000);
		rd(7'h28, 16'h0000);
		rd(7'h40, 16'h0003);
		irqIs(1'b0);
		wr(7'h44, 16'h0002);
		irqIs(1'b1);
		wr(7'h40, 16'h0002);
		irqIs(1'b0);
		rd(7'h40, 16'h0001);
		// pair control: status bits ignore writes
		wr(7'h30, 16'hFFFF);
		rd(7'h30, 16'h8F8F);
		repeat (2) @(posedge clk);
		chk(16'(txSel), 16'h0027);
		wr(7'h30, 16'h8E8F);
		repeat (2) @(posedge clk);
		chk(16'(txSel), 16'h0023);
		eng.evt(11'h110);
		rd(7'h30, 16'hAE8F);
		eng.evt(11'h080);
		rd(7'h30, 16'hAE9F);
		wr(7'h30, 16'h868F);
		repeat (2) @(posedge clk);
		chk({15'h0000, abortSeen}, 16'h0001);
		wr(7'h30, 16'h8E8F);
		rdu(8'h8E);
		eng.evt(11'h410);
		rdu(8'h86);
		eng.evt(11'h009);
		rdu(8'h8E);
		wr(7'h30, 16'h828F);
		eng.evt(11'h009);
		rdu(8'h82);
		wr(7'h30, 16'h068F);
		eng.evt(11'h009);
		rdu(8'h06);
		// an abort event ends the request and marks the buffer
		wr(7'h30, 16'h8E8F);
		eng.evt(11'h210);
		rdu(8'hC6);
		rd(7'h40, 16'h001D);
		stopTest();
	end
endmodule
